// [hw/sts_pkg.sv]
// Constants, field layout and types shared by the temperature sensor core
package sts_pkg;

	// Register addresses carried in the command byte
	localparam logic [2:0] ADDR_STATUS = 3'h0;
	localparam logic [2:0] ADDR_CONFIG = 3'h1;
	localparam logic [2:0] ADDR_TEMP   = 3'h2;
	localparam logic [2:0] ADDR_ID     = 3'h3;
	localparam logic [2:0] ADDR_CRIT   = 3'h4;
	localparam logic [2:0] ADDR_HIGH   = 3'h6;
	localparam logic [2:0] ADDR_LOW    = 3'h7;

	// Configuration field positions
	localparam int CFG_RES16    = 7;
	localparam int CFG_MODE_LSB = 5;
	localparam int CFG_IRQ      = 4;
	localparam int CFG_CT_POL   = 3;
	localparam int CFG_LIM_POL  = 2;
	localparam int CFG_FQ_LSB   = 0;

	// Operating modes in the configuration mode field
	localparam logic [1:0] MODE_NORMAL  = 2'h0;
	localparam logic [1:0] MODE_ONESHOT = 2'h1;
	localparam logic [1:0] MODE_SPS     = 2'h2;
	localparam logic [1:0] MODE_DOWN    = 2'h3;

	// Reset values
	localparam logic [7:0]  CFG_RST  = 8'h00;
	localparam logic [15:0] CRIT_RST = 16'h4980;
	localparam logic [15:0] HIGH_RST = 16'h2000;
	localparam logic [15:0] LOW_RST  = 16'h0500;

	// Result format and status layout
	localparam logic [15:0] RES13_MASK = 16'hfff8;
	localparam int          FLAG_CRIT  = 2;
	localparam int          FLAG_HIGH  = 1;
	localparam int          FLAG_LOW   = 0;
	localparam logic [3:0]  ST_PAD     = 4'h0;
	localparam logic [7:0]  BYTE_PAD   = 8'h00;
	localparam logic [2:0]  FQ_MAX     = 3'h4;

	// Serial frame layout
	localparam int         CMD_RD       = 6;
	localparam int         CMD_ADDR_LSB = 3;
	localparam logic [4:0] CNT_CMD_LAST = 5'h07;
	localparam logic [4:0] CNT_LAST8    = 5'h0f;
	localparam logic [4:0] CNT_LAST16   = 5'h17;
	localparam logic [4:0] CNT_SAT      = 5'h18;

	// Timing
	localparam int CLK_HZ        = 20_000_000;
	localparam int US_PER_S      = 1_000_000;
	localparam int FAST_TIME_US  = 6_000;
	localparam int CONV_TIME_US  = 240_000;
	localparam int SPS_CONV_US   = 60_000;
	localparam int SPS_PERIOD_US = 1_000_000;
	localparam int TMR_W         = 25;

	typedef enum logic [1:0] {
		STS_FAST     = 2'b00,
		STS_CONV     = 2'b01,
		STS_SPS_IDLE = 2'b11,
		STS_DOWN     = 2'b10
	} sts_conv_t;

endpackage

// [hw/sts_sync.sv]
// Two-stage level synchroniser with a rising-edge pulse
`timescale 1ns/1ps
module sts_sync (
	// System
	input  wire logic clk,
	input  wire logic rst,
	// Crossing signal
	input  wire logic d,
	output logic      q,
	output logic      rise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} sts_sync_t;

	sts_sync_t r_q;
	sts_sync_t r_d;

	always_comb begin
		r_d    = r_q;
		r_d.s1 = d;
		r_d.s2 = r_q.s1;
		r_d.s3 = r_q.s2;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r_q <= '1; // Starts high so an idle-high select gives no false edge
		end else begin
			r_q <= r_d;
		end
	end

	assign q    = r_q.s2;
	assign rise = r_q.s2 & ~r_q.s3;
endmodule

// [hw/sts_core.sv]
// Serial temperature sensor core: conversion sequencer, limits, alarms, serial port
`timescale 1ns/1ps
module sts_core
	import sts_pkg::*;
#(
	parameter int         FAST_CYC     = FAST_TIME_US * (CLK_HZ / US_PER_S),
	parameter int         CONV_CYC     = CONV_TIME_US * (CLK_HZ / US_PER_S),
	parameter int         SPS_CONV_CYC = SPS_CONV_US * (CLK_HZ / US_PER_S),
	parameter int         SPS_PER_CYC  = SPS_PERIOD_US * (CLK_HZ / US_PER_S),
	parameter logic [7:0] DEVICE_ID    = 8'hc3
) (
	// System
	input  wire logic        clk,
	input  wire logic        rst,
	// Serial port
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        din,
	output logic             dout,
	output logic             dout_oe_n,
	// Limit alarm pin, open drain
	input  wire logic        limit_alarm_in,
	output logic             limit_alarm_out,
	output logic             limit_alarm_oe_n,
	// Critical alarm pin, open drain
	input  wire logic        critical_alarm_out_in,
	output logic             critical_alarm_out,
	output logic             critical_alarm_out_oe_n,
	// Converter side
	input  wire logic [15:0] adc_data,
	output logic             conv_busy,
	output logic             conv_fast
);
	import sts_pkg::*;

	localparam logic [TMR_W-1:0] FAST_LD  = TMR_W'(FAST_CYC - 1);
	localparam logic [TMR_W-1:0] CONV_LD  = TMR_W'(CONV_CYC - 1);
	localparam logic [TMR_W-1:0] SCONV_LD = TMR_W'(SPS_CONV_CYC - 1);
	localparam logic [TMR_W-1:0] SIDLE_LD = TMR_W'(SPS_PER_CYC - SPS_CONV_CYC - 1);
	localparam logic [TMR_W-1:0] TMR_ONE  = TMR_W'(1);
	localparam logic [TMR_W-1:0] TMR_ZERO = '0;

	typedef struct packed {
		sts_conv_t        st;
		logic [TMR_W-1:0] tmr;
		logic [7:0]       cfg;
		logic [15:0]      temp;
		logic [15:0]      crit;
		logic [15:0]      high;
		logic [15:0]      low;
		logic [15:0]      pend_val;
		logic [2:0]       pend_brk;
		logic             pend;
		logic             nrdy;
		logic [2:0]       brk;
		logic [2:0]       fcnt;
		logic             lim_act;
		logic             ct_act;
	} sts_core_t;

	typedef struct packed {
		logic [4:0]  cnt;
		logic [15:0] sh;
		logic [7:0]  cmd;
		logic [15:0] rdsh;
	} sts_frame_t;

	typedef struct packed {
		logic        wr_pend;
		logic        rd_seen;
		logic [2:0]  addr;
		logic [15:0] data;
	} sts_xfer_t;

	sts_core_t  c_q;
	sts_core_t  c_d;
	sts_frame_t f_q;
	sts_frame_t f_d;
	sts_xfer_t  x_q;
	sts_xfer_t  x_d;
	logic       dout_q;

	logic       cs_idle;
	logic       cs_rise;
	logic       wr_pend_s;
	logic       rd_seen_s;
	logic [7:0] cmd_now;
	logic [2:0] cmd_addr;
	logic [7:0] status;
	logic [15:0] rd_word;
	logic [4:0] last_cnt;

	// Link side, serial clock domain

	assign cmd_now  = {f_q.sh[6:0], din};
	assign cmd_addr = cmd_now[CMD_ADDR_LSB +: 3];
	assign status   = {c_q.nrdy, c_q.brk[FLAG_CRIT], c_q.brk[FLAG_HIGH], c_q.brk[FLAG_LOW], ST_PAD};

	// Register values only change while the clock side sees the port idle
	always_comb begin
		case (cmd_addr)
			ADDR_STATUS: rd_word = {status, BYTE_PAD};
			ADDR_CONFIG: rd_word = {c_q.cfg, BYTE_PAD};
			ADDR_TEMP:   rd_word = c_q.temp;
			ADDR_ID:     rd_word = {DEVICE_ID, BYTE_PAD};
			ADDR_CRIT:   rd_word = c_q.crit;
			ADDR_HIGH:   rd_word = c_q.high;
			ADDR_LOW:    rd_word = c_q.low;
			default:     rd_word = '0;
		endcase
	end

	always_comb begin
		case (f_q.cmd[CMD_ADDR_LSB +: 3])
			ADDR_TEMP, ADDR_CRIT, ADDR_HIGH, ADDR_LOW: last_cnt = CNT_LAST16;
			default:                                   last_cnt = CNT_LAST8;
		endcase
	end

	always_comb begin
		f_d     = f_q;
		f_d.cnt = (f_q.cnt == CNT_SAT) ? f_q.cnt : f_q.cnt + 5'h01;
		f_d.sh  = {f_q.sh[14:0], din};
		if (f_q.cnt == CNT_CMD_LAST) begin
			f_d.cmd = cmd_now;
			if (cmd_now[CMD_RD]) begin
				f_d.rdsh = rd_word;
			end
		end else if (f_q.cnt > CNT_CMD_LAST) begin
			f_d.rdsh = {f_q.rdsh[14:0], 1'b0};
		end
	end

	// Frame state is cleared by select going high, so no edge is needed between frames
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			f_q <= '0;
		end else begin
			f_q <= f_d;
		end
	end

	always_comb begin
		x_d = x_q;
		if (!cs_n) begin
			if (f_q.cnt == 5'h00) begin
				x_d.wr_pend = 1'b0;
				x_d.rd_seen = 1'b0;
			end
			if (f_q.cnt == CNT_CMD_LAST && cmd_now[CMD_RD]) begin
				x_d.rd_seen = 1'b1;
			end
			if (f_q.cnt == last_cnt && !f_q.cmd[CMD_RD]) begin
				x_d.wr_pend = 1'b1;
				x_d.addr    = f_q.cmd[CMD_ADDR_LSB +: 3];
				x_d.data    = {f_q.sh[14:0], din};
			end
		end
	end

	// Held across frames; the clock side samples it only after select rises
	always_ff @(posedge sclk) begin
		x_q <= x_d;
	end

	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			dout_q <= 1'b0;
		end else begin
			dout_q <= f_q.rdsh[15];
		end
	end

	assign dout      = dout_q;
	assign dout_oe_n = cs_n;

	// Crossings into the system clock domain

	sts_sync u_sync_cs (
		.clk  (clk),
		.rst  (rst),
		.d    (cs_n),
		.q    (cs_idle),
		.rise (cs_rise)
	);

	sts_sync u_sync_wr (
		.clk  (clk),
		.rst  (rst),
		.d    (x_q.wr_pend),
		.q    (wr_pend_s),
		.rise ()
	);

	sts_sync u_sync_rd (
		.clk  (clk),
		.rst  (rst),
		.d    (x_q.rd_seen),
		.q    (rd_seen_s),
		.rise ()
	);

	// System side: sequencer, registers, alarms

	always_comb begin
		logic        done;
		logic        start;
		logic [15:0] val;
		logic [15:0] stored;
		logic        crit_b;
		logic        high_b;
		logic        low_b;
		logic [2:0]  nf;
		logic        reached;
		logic        lim_c;
		logic        ct_c;
		done    = 1'b0;
		start   = 1'b0;
		val     = c_q.cfg[CFG_RES16] ? adc_data : (adc_data & RES13_MASK);
		crit_b  = $signed(val) > $signed(c_q.crit);
		high_b  = $signed(val) > $signed(c_q.high);
		low_b   = $signed(val) < $signed(c_q.low);
		stored  = c_q.cfg[CFG_RES16] ? val : {val[15:3], crit_b, high_b, low_b};
		nf      = '0;
		reached = 1'b0;
		lim_c   = 1'b0;
		ct_c    = 1'b0;
		c_d     = c_q;

		// Timers run from the system clock alone
		case (c_q.st)
			STS_FAST, STS_CONV: begin
				if (c_q.tmr == TMR_ZERO) begin
					done = 1'b1;
				end else begin
					c_d.tmr = c_q.tmr - TMR_ONE;
				end
			end
			STS_SPS_IDLE: begin
				if (c_q.tmr == TMR_ZERO) begin
					start = 1'b1;
				end else begin
					c_d.tmr = c_q.tmr - TMR_ONE;
				end
			end
			STS_DOWN: begin
			end
			default: begin
				c_d.st  = STS_FAST;
				c_d.tmr = FAST_LD;
			end
		endcase

		// A result held back during a transfer lands once the port is idle
		if (c_q.pend && cs_idle) begin
			c_d.temp = c_q.pend_val;
			c_d.brk  = c_q.pend_brk;
			c_d.pend = 1'b0;
			c_d.nrdy = 1'b0;
		end

		// Read clear comes first so an alarm raised in the same cycle wins
		if (cs_rise && rd_seen_s && c_q.cfg[CFG_IRQ]) begin
			c_d.lim_act = 1'b0;
			c_d.ct_act  = 1'b0;
		end

		if (done) begin
			nf = (crit_b | high_b | low_b) ?
				((c_q.fcnt == FQ_MAX) ? FQ_MAX : c_q.fcnt + 3'h1) : 3'h0;
			reached   = nf > {1'b0, c_q.cfg[CFG_FQ_LSB +: 2]};
			lim_c     = reached & (high_b | low_b);
			ct_c      = reached & crit_b;
			c_d.fcnt  = nf;
			if (c_q.cfg[CFG_IRQ]) begin
				c_d.lim_act = c_d.lim_act | lim_c;
				c_d.ct_act  = c_d.ct_act | ct_c;
			end else begin
				c_d.lim_act = lim_c;
				c_d.ct_act  = ct_c;
			end
			// Status flags wait with the result so a read never catches them mid-update
			if (cs_idle) begin
				c_d.temp = stored;
				c_d.brk  = {crit_b, high_b, low_b};
				c_d.nrdy = 1'b0;
			end else begin
				c_d.pend_val = stored;
				c_d.pend_brk = {crit_b, high_b, low_b};
				c_d.pend     = 1'b1;
			end
			case (c_q.cfg[CFG_MODE_LSB +: 2])
				MODE_NORMAL: start = 1'b1;
				MODE_SPS: begin
					c_d.st  = STS_SPS_IDLE;
					c_d.tmr = SIDLE_LD;
				end
				default: c_d.st = STS_DOWN;
			endcase
		end

		// Register writes commit when select rises after a write frame
		if (cs_rise && wr_pend_s) begin
			case (x_q.addr)
				ADDR_CONFIG: begin
					c_d.cfg = x_q.data[7:0];
					if (x_q.data[CFG_MODE_LSB +: 2] == MODE_ONESHOT || c_q.st == STS_DOWN) begin
						start = 1'b1;
					end
				end
				ADDR_CRIT: c_d.crit = x_q.data;
				ADDR_HIGH: c_d.high = x_q.data;
				ADDR_LOW:  c_d.low  = x_q.data;
				default: begin
				end
			endcase
		end

		if (c_d.cfg[CFG_MODE_LSB +: 2] == MODE_DOWN) begin
			c_d.st = STS_DOWN;
		end else if (start) begin
			c_d.st  = STS_CONV;
			c_d.tmr = (c_d.cfg[CFG_MODE_LSB +: 2] == MODE_SPS) ? SCONV_LD : CONV_LD;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			c_q          <= '0;
			c_q.st       <= STS_FAST;
			c_q.tmr      <= FAST_LD;
			c_q.cfg      <= CFG_RST;
			c_q.crit     <= CRIT_RST;
			c_q.high     <= HIGH_RST;
			c_q.low      <= LOW_RST;
			c_q.nrdy     <= 1'b1;
		end else begin
			c_q <= c_d;
		end
	end

	// Open drain: only ever pull low or release
	assign limit_alarm_out         = 1'b0;
	assign limit_alarm_oe_n        = ~(c_q.lim_act ^ c_q.cfg[CFG_LIM_POL]);
	assign critical_alarm_out      = 1'b0;
	assign critical_alarm_out_oe_n = ~(c_q.ct_act ^ c_q.cfg[CFG_CT_POL]);
	assign conv_busy = (c_q.st == STS_FAST) || (c_q.st == STS_CONV);
	assign conv_fast = (c_q.st == STS_FAST);
endmodule

// [testbench/sts_core_props.sv]
// Port assertions for the temperature sensor core
`timescale 1ns/1ps
module sts_core_props
	import sts_pkg::*;
#(
	parameter int FAST_CYC = 20
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        cs_n,
	input wire logic        dout_oe_n,
	input wire logic        limit_alarm_out,
	input wire logic        limit_alarm_oe_n,
	input wire logic        critical_alarm_out,
	input wire logic        critical_alarm_out_oe_n,
	input wire logic [15:0] adc_data,
	input wire logic        conv_busy,
	input wire logic        conv_fast
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	localparam int FMIN = FAST_CYC - 1;
	localparam int FMAX = FAST_CYC + 1;
	int fcnt_q;
	// Length of the first conversion, one cycle of slack either way
	always_ff @(posedge clk) fcnt_q <= (rst || !conv_fast) ? 0 : fcnt_q + 1;
	AST_OD_LIM: assert property (limit_alarm_out == 1'b0) else $error("limit pin driven high");
	AST_OD_CT: assert property (critical_alarm_out == 1'b0) else $error("crit pin driven high");
	AST_OE_CS: assert property (dout_oe_n == cs_n) else $error("dout enable off select");
	AST_REL: assert property ($fell(rst) |-> limit_alarm_oe_n && critical_alarm_out_oe_n)
		else $error("alarm active after reset");
	AST_FAST_ON: assert property ($fell(rst) |-> conv_fast && conv_busy)
		else $error("no fast conversion");
	AST_FAST_LEN: assert property ($fell(conv_fast) |-> fcnt_q >= FMIN && fcnt_q <= FMAX)
		else $error("fast conversion length");
	AST_CONT: assert property ($fell(conv_fast) |-> conv_busy [*8])
		else $error("conversion not continuous");
	AST_CRIT: assert property ($fell(conv_fast) && $signed(adc_data) > $signed(CRIT_RST + 16'h7)
		|-> ##[0:3] !critical_alarm_out_oe_n) else $error("crit alarm missing");
	AST_HIGH: assert property ($fell(conv_fast) && $signed(adc_data) > $signed(HIGH_RST + 16'h7)
		|-> ##[0:3] !limit_alarm_oe_n) else $error("limit alarm missing");
	COV_FAST: cover property ($fell(conv_fast));
	COV_CT: cover property ($fell(critical_alarm_out_oe_n));
	COV_LIM: cover property ($rose(limit_alarm_oe_n));
	COV_FRAME: cover property ($fell(cs_n));
endmodule

bind sts_core sts_core_props #(.FAST_CYC(FAST_CYC)) u_props (.clk, .rst, .cs_n, .dout_oe_n,
	.limit_alarm_out, .limit_alarm_oe_n, .critical_alarm_out, .critical_alarm_out_oe_n,
	.adc_data, .conv_busy, .conv_fast);

// [testbench/sts_host.sv]
// Host serial controller model for the sensor port
`timescale 1ns/1ps
module sts_host (
	// Serial port
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout
);
	realtime half = 3.0;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din  = 1'b0;
	end
	// Command byte then n data bits, MSB first; clock stands still between frames
	task automatic xfer(input logic rw, input logic [2:0] a, input int n,
		input logic [15:0] wd, output logic [15:0] q);
		logic [23:0] sh;
		sh = {1'b0, rw, a, 3'h0, wd << (16 - n)};
		q = 16'h0;
		#1.3;
		cs_n = 1'b0;
		for (int k = 0; k < 8 + n; k++) begin
			din = sh[23];
			sh = sh << 1;
			#(half) sclk = 1'b1;
			if (k >= 8) q = {q[14:0], dout};
			#(half) sclk = 1'b0;
		end
		#(half) cs_n = 1'b1;
		// Released line: no stale value left on it
		din = ~din;
		#200;
	endtask
endmodule

// [testbench/sts_core_tb.sv]
// Self-checking bench for the temperature sensor core
`timescale 1ns/1ps
module sts_core_tb;
	import sts_pkg::*;
	logic        clk, rst, sclk, cs_n, din, dout, dout_oe_n;
	logic        lim_out, lim_oe_n, ct_out, ct_oe_n, busy, fast;
	logic [15:0] adc, rv, hi;
	int          errors, samples_checked, seed;
	logic [1:0]  modes [3] = '{MODE_DOWN, MODE_ONESHOT, MODE_SPS};
	localparam logic [7:0] ID_VAL = 8'h5a; // Arbitrary id value
	// Open-drain pins with pull-ups
	wire         lim_pin = lim_oe_n ? 1'b1 : lim_out;
	wire         ct_pin  = ct_oe_n ? 1'b1 : ct_out;

	sts_core #(.FAST_CYC(20), .CONV_CYC(50), .SPS_CONV_CYC(20), .SPS_PER_CYC(80),
		.DEVICE_ID(ID_VAL)) dut (
		.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.dout_oe_n(dout_oe_n), .limit_alarm_in(lim_pin), .limit_alarm_out(lim_out),
		.limit_alarm_oe_n(lim_oe_n), .critical_alarm_out_in(ct_pin),
		.critical_alarm_out(ct_out), .critical_alarm_out_oe_n(ct_oe_n),
		.adc_data(adc), .conv_busy(busy), .conv_fast(fast));
	sts_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_for(ref logic s, input logic v);
		for (int k = 0; s !== v; k++) begin
			if (k > 100) begin
				errors++;
				wrap_up();
			end
			cyc(1);
		end
	endtask
	task automatic rd(input logic [2:0] a, input int n);
		host.xfer(1'b1, a, n, 16'h0, rv);
		cyc(1);
	endtask
	task automatic wr(input logic [2:0] a, input int n, input logic [15:0] v);
		logic [15:0] d;
		host.xfer(1'b0, a, n, v, d);
		cyc(1);
	endtask
	// 13-bit result with crit, high, low flags against the reset limits
	function automatic logic [15:0] t13(input logic [15:0] a);
		return (a & RES13_MASK) | {13'h0, $signed(a) > $signed(CRIT_RST),
			$signed(a) > $signed(HIGH_RST), $signed(a) < $signed(LOW_RST)};
	endfunction

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#2ms;
		errors++;
		wrap_up();
	end
	initial begin
		errors = 0;
		samples_checked = 0;
		seed = 32'he0fa;
		rst = 1'b1;
		adc = 16'h5000;
		cyc(20);
		rst = 1'b0;
		wait_for(fast, 1'b0);
		cyc(4);
		chk({ct_pin, lim_pin}, 2'b00);
		rd(ADDR_TEMP, 16);
		chk(rv, t13(adc));
		rd(ADDR_STATUS, 8);
		chk(rv, {BYTE_PAD, 1'b0, 1'b1, 1'b1, 1'b0, ST_PAD});
		rd(ADDR_CONFIG, 8);
		chk(rv, {BYTE_PAD, CFG_RST});
		rd(ADDR_CRIT, 16);
		chk(rv, CRIT_RST);
		rd(ADDR_HIGH, 16);
		chk(rv, HIGH_RST);
		rd(ADDR_LOW, 16);
		chk(rv, LOW_RST);
		// In-band value, a multiple of 8 so masking cannot hide a flag
		adc = 16'h0600 + 16'($random(seed) & 16'h0ff8);
		cyc(110);
		chk({ct_pin, lim_pin}, 2'b11);
		rd(ADDR_TEMP, 16);
		chk(rv, t13(adc));
		hi = 16'h0800 | 16'($random(seed) & 16'h3ff0);
		wr(ADDR_HIGH, 16, hi);
		rd(ADDR_HIGH, 16);
		chk(rv, hi);
		adc = hi + 16'h1;
		wr(ADDR_CONFIG, 8, 16'h0080);
		cyc(110);
		rd(ADDR_TEMP, 16);
		chk(rv, adc);
		chk({ct_pin, lim_pin}, 2'b10);
		wr(ADDR_CONFIG, 8, 16'h0084);
		cyc(4);
		chk(lim_pin, 1'b1);
		adc = hi - 16'h8;
		cyc(110);
		chk(lim_pin, 1'b0);
		wr(ADDR_CONFIG, 8, 16'h0090);
		adc = hi + 16'h10;
		cyc(60);
		chk(lim_pin, 1'b0);
		adc = hi - 16'h8;
		cyc(110);
		chk(lim_pin, 1'b0);
		host.half = 40.0;
		rd(ADDR_ID, 8);
		chk(rv, {BYTE_PAD, ID_VAL});
		host.half = 3.0;
		cyc(4);
		chk(lim_pin, 1'b1);
		wr(ADDR_CRIT, 16, CRIT_RST - 16'h8);
		rd(ADDR_CRIT, 16);
		chk(rv, CRIT_RST - 16'h8);
		wr(ADDR_LOW, 16, LOW_RST + 16'h8);
		rd(ADDR_LOW, 16);
		chk(rv, LOW_RST + 16'h8);
		// Four faults needed; active-high crit pin sits low while idle
		wr(ADDR_CONFIG, 8, 16'h008b);
		adc = LOW_RST - 16'h8;
		cyc(110);
		chk({ct_pin, lim_pin}, 2'b01);
		cyc(110);
		chk({ct_pin, lim_pin}, 2'b00);
		foreach (modes[m]) begin
			wr(ADDR_CONFIG, 8, {8'h0, 1'b0, modes[m], 5'h0});
			cyc(70);
			chk(busy, 1'b0);
		end
		wr(ADDR_CONFIG, 8, {8'h0, 1'b0, MODE_NORMAL, 5'h0});
		wait_for(busy, 1'b1);
		chk(busy, 1'b1);
		wrap_up();
	end
endmodule
